// ==== logic/mode_monitor_pkg.sv ====
// shared constants and types for the operating mode select and monitor block
package mode_monitor_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register bus geometry
    localparam int unsigned REG_AW = 8;
    localparam int unsigned REG_DW = 8;

    // offset of the mode monitor register on the register port
    localparam logic [7:0] MONITOR_OFFSET = 8'h00;

    // unmapped reads and idle cycles return this value
    localparam logic [7:0] IDLE_RDATA = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // field layout of the mode monitor register
    localparam int unsigned EXP_BIT = 7;
    localparam int unsigned RSVD_HI = 6;
    localparam int unsigned RSVD_LO = 2;
    localparam int unsigned STAT_HI_BIT = 1;
    localparam int unsigned STAT_LO_BIT = 0;

    // reset values
    localparam logic EXP_RESET = 1'b0;
    localparam logic [1:0] STATUS_RESET = 2'h0;
    localparam logic [1:0] SYNC_RESET = 2'h0;
    localparam logic [1:0] RST_PIPE_RESET = 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    // strap encodings {mode_pin_high, mode_pin_low}
    localparam logic [1:0] PINS_ADVANCED = 2'h2;
    localparam logic [1:0] PINS_NORMAL = 2'h3;

    // cycles after reset release until the pin synchroniser holds real levels
    localparam logic [1:0] SYNC_SETTLE = 2'h2;

    // address widths: full physical space, normal-mode space and CPU effective address
    localparam int unsigned PHYS_AW = 24;
    localparam int unsigned NORMAL_AW = 16;
    localparam int unsigned EA_W = 32;

    ////////////////////////////////////////////////////////////////////////////
    // decoded operating mode, one-hot
    typedef enum logic [2:0] {
        MODE_UNSUPPORTED = 3'h1,
        MODE_ADVANCED = 3'h2,
        MODE_NORMAL = 3'h4
    } mode_t;

endpackage : mode_monitor_pkg

// ==== logic/pin_sync.sv ====
// two-flop synchroniser for the mode strap pins
`timescale 1ns/100ps
module pin_sync (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst_n,
    // asynchronous pins and their synchronised copy
    input wire logic [1:0] pin_async,
    output logic [1:0] pin_sync_q
);

    logic [1:0] stage1_q;
    logic [1:0] stage1_d;
    logic [1:0] stage2_d;

    // first stage feeds only the second stage, never any other logic
    always_comb begin
        stage1_d = pin_async;
        stage2_d = stage1_q;
    end

    // both stages on every edge
    always_ff @(posedge core_clk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            stage1_q <= mode_monitor_pkg::SYNC_RESET;
            pin_sync_q <= mode_monitor_pkg::SYNC_RESET;
        end else begin
            stage1_q <= stage1_d;
            pin_sync_q <= stage2_d;
        end
    end

endmodule : pin_sync

// ==== logic/mode_decoder.sv ====
// decode of the strapped mode pins into the operating mode and its features
`timescale 1ns/100ps
module mode_decoder (
    // synchronised strap levels {high, low}
    input wire logic [1:0] pins,
    // decoded mode and features
    output mode_monitor_pkg::mode_t mode,
    output logic rom_enable,
    output logic single_chip
);

    // only two strap codes are meaningful; anything else is flagged
    always_comb begin
        mode = mode_monitor_pkg::MODE_UNSUPPORTED;
        rom_enable = 1'b0;
        single_chip = 1'b0;
        unique case (pins)
            mode_monitor_pkg::PINS_ADVANCED: begin
                mode = mode_monitor_pkg::MODE_ADVANCED;
                rom_enable = 1'b1;
                single_chip = 1'b1;
            end
            mode_monitor_pkg::PINS_NORMAL: begin
                mode = mode_monitor_pkg::MODE_NORMAL;
                single_chip = 1'b1;
            end
            default: begin
                mode = mode_monitor_pkg::MODE_UNSUPPORTED;
            end
        endcase
    end

endmodule : mode_decoder

// ==== logic/operating_mode_select_monitor.sv ====
// operating mode select from strap pins with a software mode monitor register
`timescale 1ns/100ps
module operating_mode_select_monitor (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // strap pins
    input wire logic mode_pin_high,
    input wire logic mode_pin_low,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // decoded mode
    output logic cpu_advanced,
    output logic single_chip,
    output logic rom_enable,
    output logic mode_fault,
    // address path
    input wire logic [31:0] cpu_ea,
    output logic [23:0] phys_addr
);

    ////////////////////////////////////////////////////////////////////////////
    // reset release

    logic [1:0] rst_pipe_q;
    logic [1:0] rst_pipe_d;
    logic sys_rst_n;

    // asserts at once, releases two edges later so release is clean
    always_comb begin
        rst_pipe_d = {rst_pipe_q[0], 1'b1};
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe_q <= mode_monitor_pkg::RST_PIPE_RESET;
        end else begin
            rst_pipe_q <= rst_pipe_d;
        end
    end

    assign sys_rst_n = rst_pipe_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // strap input path

    logic [1:0] pins_s;
    mode_monitor_pkg::mode_t mode_dec;
    logic rom_dec;
    logic chip_dec;

    // straps are asynchronous to core_clk
    pin_sync u_pin_sync (
        .core_clk(core_clk),
        .sys_rst_n(sys_rst_n),
        .pin_async({mode_pin_high, mode_pin_low}),
        .pin_sync_q(pins_s)
    );

    mode_decoder u_mode_decoder (
        .pins(pins_s),
        .mode(mode_dec),
        .rom_enable(rom_dec),
        .single_chip(chip_dec)
    );

    ////////////////////////////////////////////////////////////////////////////
    // register port decode

    // the monitor register occupies one address; all others are unmapped
    function automatic logic monitor_hit(input logic [7:0] addr);
        monitor_hit = (addr == mode_monitor_pkg::MONITOR_OFFSET);
    endfunction : monitor_hit

    logic hit_wr;
    logic hit_rd;

    assign hit_wr = reg_wr && monitor_hit(reg_addr);
    assign hit_rd = reg_rd && monitor_hit(reg_addr);

    ////////////////////////////////////////////////////////////////////////////
    // mode monitor register state

    logic exp_q;
    logic exp_d;
    logic latched_q;
    logic latched_d;
    logic [1:0] status_q;
    logic [1:0] status_d;
    logic [1:0] shown;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    // until the first read the status bits are transparent to the pins,
    // so the reset value is whatever is strapped, never a fixed code
    assign shown = latched_q ? status_q : pins_s;

    always_comb begin
        exp_d = exp_q;
        latched_d = latched_q;
        status_d = status_q;
        rdata_d = mode_monitor_pkg::IDLE_RDATA;
        if (hit_wr) begin
            // only the spare bit takes write data
            exp_d = reg_wdata[mode_monitor_pkg::EXP_BIT];
        end
        if (hit_rd) begin
            latched_d = 1'b1;
            status_d = pins_s;
            rdata_d[mode_monitor_pkg::EXP_BIT] = exp_q;
            // bits 6..2 stay at the idle value zero
            rdata_d[mode_monitor_pkg::STAT_HI_BIT] = pins_s[1];
            rdata_d[mode_monitor_pkg::STAT_LO_BIT] = pins_s[0];
        end
    end

    // reset drops the latch, handing the status bits back to the pins
    always_ff @(posedge core_clk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            exp_q <= mode_monitor_pkg::EXP_RESET;
            latched_q <= 1'b0;
            status_q <= mode_monitor_pkg::STATUS_RESET;
            rdata_q <= mode_monitor_pkg::IDLE_RDATA;
        end else begin
            exp_q <= exp_d;
            latched_q <= latched_d;
            status_q <= status_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // operating mode and address path

    mode_monitor_pkg::mode_t mode_q;
    mode_monitor_pkg::mode_t mode_d;
    logic rom_q;
    logic rom_d;
    logic chip_q;
    logic chip_d;
    logic [23:0] addr_q;
    logic [23:0] addr_d;

    // mode tracks the synchronised straps; the board keeps them steady,
    // so once the synchroniser has filled after reset, a change here only happens if the strap is misused
    always_comb begin
        mode_d = mode_dec;
        rom_d = rom_dec;
        chip_d = chip_dec;
        addr_d = '0;
        unique case (mode_q)
            mode_monitor_pkg::MODE_ADVANCED: begin
                addr_d = cpu_ea[mode_monitor_pkg::PHYS_AW-1:0];
            end
            mode_monitor_pkg::MODE_NORMAL: begin
                addr_d[mode_monitor_pkg::NORMAL_AW-1:0] =
                    cpu_ea[mode_monitor_pkg::NORMAL_AW-1:0];
            end
            default: begin
                // unusable strap: keep to the narrow space as the safe choice
                addr_d[mode_monitor_pkg::NORMAL_AW-1:0] =
                    cpu_ea[mode_monitor_pkg::NORMAL_AW-1:0];
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            mode_q <= mode_monitor_pkg::MODE_UNSUPPORTED;
            rom_q <= 1'b0;
            chip_q <= 1'b0;
            addr_q <= '0;
        end else begin
            mode_q <= mode_d;
            rom_q <= rom_d;
            chip_q <= chip_d;
            addr_q <= addr_d;
        end
    end

    // flag is high through reset and the synchroniser fill, and afterwards shows the board broke the strap contract
    assign cpu_advanced = (mode_q == mode_monitor_pkg::MODE_ADVANCED);
    assign mode_fault = (mode_q == mode_monitor_pkg::MODE_UNSUPPORTED);
    assign single_chip = chip_q;
    assign rom_enable = rom_q;
    assign phys_addr = addr_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    // counts edges since reset release so pin-path checks skip the fill time
    logic [1:0] settle_q;

    always_ff @(posedge core_clk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            settle_q <= 2'h0;
        end else if (settle_q != mode_monitor_pkg::SYNC_SETTLE) begin
            settle_q <= settle_q + 2'h1;
        end
    end

    property p_decode_advanced;
        @(posedge core_clk) disable iff (!sys_rst_n)
        (pins_s == mode_monitor_pkg::PINS_ADVANCED) |=>
            (cpu_advanced && rom_enable && single_chip && !mode_fault);
    endproperty
    a_decode_advanced: assert property (p_decode_advanced)
        else $error("advanced strap not decoded");

    property p_decode_normal;
        @(posedge core_clk) disable iff (!sys_rst_n)
        (pins_s == mode_monitor_pkg::PINS_NORMAL) |=>
            (mode_q == mode_monitor_pkg::MODE_NORMAL) && !rom_enable && single_chip;
    endproperty
    a_decode_normal: assert property (p_decode_normal)
        else $error("normal strap not decoded");

    property p_spare_readback;
        @(posedge core_clk) disable iff (!sys_rst_n)
        (hit_wr ##1 hit_rd) |=>
            (reg_rdata[mode_monitor_pkg::EXP_BIT] == $past(reg_wdata[7], 2));
    endproperty
    a_spare_readback: assert property (p_spare_readback)
        else $error("spare bit did not return written value");

    property p_reserved_zero;
        @(posedge core_clk) disable iff (!sys_rst_n)
        hit_wr |=> (reg_rdata[mode_monitor_pkg::RSVD_HI:mode_monitor_pkg::RSVD_LO] == 5'h00)
            ##1 (reg_rdata[mode_monitor_pkg::RSVD_HI:mode_monitor_pkg::RSVD_LO] == 5'h00);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits read nonzero");

    property p_status_write_ignored;
        @(posedge core_clk) disable iff (!sys_rst_n)
        (hit_wr && latched_q) |=> (status_q == $past(status_q)) && latched_q;
    endproperty
    a_status_write_ignored: assert property (p_status_write_ignored)
        else $error("write altered status bits");

    property p_read_captures;
        @(posedge core_clk) disable iff (!sys_rst_n)
        hit_rd |=> latched_q && (status_q == $past(pins_s))
            && (reg_rdata[1:0] == $past(pins_s));
    endproperty
    a_read_captures: assert property (p_read_captures)
        else $error("read did not latch pin levels");

    property p_latch_holds;
        @(posedge core_clk) disable iff (!sys_rst_n)
        (latched_q && !hit_rd) |=> $stable(status_q) && latched_q;
    endproperty
    a_latch_holds: assert property (p_latch_holds)
        else $error("latched status moved without a read");

    // compares against the raw pins, so a wrong mux or a stuck sync stage shows up
    property p_follow_after_reset;
        @(posedge core_clk) disable iff (!sys_rst_n)
        (!latched_q && (settle_q == mode_monitor_pkg::SYNC_SETTLE)) |->
            (shown == $past({mode_pin_high, mode_pin_low}, 2));
    endproperty
    a_follow_after_reset: assert property (p_follow_after_reset)
        else $error("status bits not following pins before first read");

    property p_normal_addr;
        @(posedge core_clk) disable iff (!sys_rst_n)
        (mode_q == mode_monitor_pkg::MODE_NORMAL) |=>
            (phys_addr == {8'h00, $past(cpu_ea[15:0])});
    endproperty
    a_normal_addr: assert property (p_normal_addr)
        else $error("normal mode address not cut to 16 bits");

    property p_sync_delay;
        @(posedge core_clk) disable iff (!sys_rst_n)
        (settle_q == mode_monitor_pkg::SYNC_SETTLE) |->
            (pins_s == $past({mode_pin_high, mode_pin_low}, 2));
    endproperty
    a_sync_delay: assert property (p_sync_delay)
        else $error("pin synchroniser delay is not two cycles");

endmodule : operating_mode_select_monitor

// ==== tb/strap_board.sv ====
// board strapping model that drives the two mode pins
`timescale 1ns/100ps
module strap_board (
    // clock and reset seen on the board
    input wire logic core_clk,
    input wire logic rst_n,
    // strap choice from the bench: 1 gives normal, 0 gives advanced
    input wire logic normal_sel,
    // strap pins
    output logic mode_pin_high,
    output logic mode_pin_low
);
    logic normal_q;

    // the jumper is only moved while the device sits in reset
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            normal_q <= normal_sel;
        end
    end

    // high pin tied to one, so only codes 10 and 11 can ever appear
    assign mode_pin_high = 1'b1;
    assign mode_pin_low = normal_q;
endmodule : strap_board

// ==== tb/tb_operating_mode_select_monitor.sv ====
// self-checking bench for the mode select and mode monitor block
`timescale 1ns/100ps
module tb_operating_mode_select_monitor;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic normal_sel = 1'b0;
    logic mode_pin_high;
    logic mode_pin_low;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic cpu_advanced;
    logic single_chip;
    logic rom_enable;
    logic mode_fault;
    logic [31:0] cpu_ea = 32'h00000000;
    logic [23:0] phys_addr;
    int fails = 0;
    int n_tests = 0;
    int seed = 79;
    int exp_bit7;
    int strap;
    int ea_q[$];
    logic [7:0] rd;
    logic [7:0] wd;
    logic [7:0] bad;
    logic [31:0] ea_mask;

    ////////////////////////////////////////////////////////////////////////////
    // clock at 40 MHz
    always #12.5 core_clk = ~core_clk;

    strap_board board_u (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .normal_sel(normal_sel),
        .mode_pin_high(mode_pin_high),
        .mode_pin_low(mode_pin_low)
    );

    operating_mode_select_monitor dut_u (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .mode_pin_high(mode_pin_high),
        .mode_pin_low(mode_pin_low),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .cpu_advanced(cpu_advanced),
        .single_chip(single_chip),
        .rom_enable(rom_enable),
        .mode_fault(mode_fault),
        .cpu_ea(cpu_ea),
        .phys_addr(phys_addr)
    );

    ////////////////////////////////////////////////////////////////////////////
    // comparison, verdict and bus tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic stop_test();
        $display("counts: %0d compares, %0d mismatches", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    // strobes are left up so the next request can follow with no gap;
    // bus_idle drops them once a run of requests ends
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        reg_rd <= 1'b0;
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
    endtask : reg_write

    // read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        #1 d = reg_rdata;
    endtask : reg_read

    // read data must fall back to zero one cycle after the last read
    task automatic bus_idle();
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(posedge core_clk);
        #1 check("rdata idle", reg_rdata, 32'h0);
    endtask : bus_idle

    // model of the register: spare bit stored, pins in the low two bits
    function automatic logic [31:0] exp_reg();
        return (exp_bit7 << 7) | strap;
    endfunction : exp_reg

    ////////////////////////////////////////////////////////////////////////////
    // watchdog at 20000 cycles, far above the 200 or so cycles the tests need
    initial begin
        #(25 * 20000);
        fails++;
        stop_test();
    end

    // main sequence, once per legal strap code; the second pass resets mid-run
    initial begin
        for (int s = 2; s <= 3; s++) begin
            strap = s;
            exp_bit7 = 0;
            ea_mask = (s == 3) ? 32'h0000ffff : 32'h00ffffff;
            @(posedge core_clk);
            rst_n <= 1'b0;
            normal_sel <= (s == 3);
            repeat (19) @(posedge core_clk);
            #1;
            check("mode_fault in reset", mode_fault, 1);
            check("cpu_advanced in reset", cpu_advanced, 0);
            check("phys_addr in reset", phys_addr, 0);
            @(posedge core_clk);
            rst_n <= 1'b1;
            repeat (8) @(posedge core_clk);
            #1;
            check("cpu_advanced", cpu_advanced, s == 2);
            check("rom_enable", rom_enable, s == 2);
            check("single_chip", single_chip, 1);
            check("mode_fault", mode_fault, 0);
            reg_read(mode_monitor_pkg::MONITOR_OFFSET, rd);
            check("reset value", rd, exp_reg());
            bus_idle();
            // random writes, each read back with no gap: spare bit kept, rest untouched
            for (int i = 0; i < 12; i++) begin
                wd = $random(seed);
                reg_write(mode_monitor_pkg::MONITOR_OFFSET, wd);
                exp_bit7 = wd[7];
                reg_read(mode_monitor_pkg::MONITOR_OFFSET, rd);
                check("monitor", rd, exp_reg());
                check("zero field", rd[6:2], 0);
                check("pin bits", rd[1:0], strap);
                reg_read(mode_monitor_pkg::MONITOR_OFFSET, rd);
                check("relatch", rd, exp_reg());
                bus_idle();
            end
            // unmapped place: write dropped, read gives zero
            bad = $random(seed);
            bad = bad | 8'h01;
            reg_write(bad, 8'hff);
            reg_read(bad, rd);
            check("unmapped", rd, 32'h0);
            reg_read(mode_monitor_pkg::MONITOR_OFFSET, rd);
            check("after unmapped", rd, exp_reg());
            // software leaves the spare bit at its reset value
            reg_write(mode_monitor_pkg::MONITOR_OFFSET, 8'h00);
            exp_bit7 = 0;
            bus_idle();
            // address path: one cycle latency, width set by the mode
            for (int i = 0; i < 16; i++) begin
                @(posedge core_clk);
                cpu_ea <= $random(seed);
                #1;
                ea_q.push_back(cpu_ea);
                if (i > 0) begin
                    check("phys_addr", phys_addr, ea_q[i - 1] & ea_mask);
                end
            end
            ea_q.delete();
            $display("test strap %0d done", s);
        end
        stop_test();
    end
endmodule : tb_operating_mode_select_monitor
